// >>> rtl/dsrp_map.svh
`ifndef DSRP_MAP_SVH
`define DSRP_MAP_SVH
// ==========================================
// Device address and link constants
`define DSRP_DEV_ADDR 7'h18
`define DSRP_QTR_CYC 250
`define DSRP_QTR_MIN 4
`define DSRP_CNT_W 16
`define DSRP_SYNC_W 3
// ==========================================
// Bit positions within a symbol or frame
`define DSRP_ACK_BIT 5'h08
`define DSRP_SPI_CMD_LAST 5'h07
`define DSRP_SPI_LAST 5'h0F
`define DSRP_Q_FIRST 2'h0
`define DSRP_Q_LAST 2'h3
`define DSRP_Q_SPI_SMP 2'h1
`define DSRP_Q_SCL_HI 2'h2
// ==========================================
// Two-wire byte steps
`define DSRP_STEP_AW 3'h0
`define DSRP_STEP_REG 3'h1
`define DSRP_STEP_DAT 3'h2
`define DSRP_STEP_AR 3'h3
`define DSRP_STEP_RD 3'h4
// ==========================================
// Pin levels
`define DSRP_OD_LOW 1'h0
`define DSRP_RX_IDLE 8'hFF
`define DSRP_SPI_FILL 8'h00
`endif

// >>> rtl/dsrp_pkg.sv
`include "dsrp_map.svh"
package dsrp_pkg;
	// ==========================================
	// Controller states
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_I2C_START = 8'h02,
		ST_I2C_BIT = 8'h04,
		ST_I2C_STOP = 8'h08,
		ST_SPI_START = 8'h10,
		ST_SPI_BIT = 8'h20,
		ST_SPI_END = 8'h40,
		ST_DONE = 8'h80
	} dsrp_state_t;

	// ==========================================
	// Controller state record
	typedef struct packed {
		dsrp_state_t st;
		logic [`DSRP_CNT_W-1:0] cnt;
		logic [1:0] q;
		logic [4:0] bitn;
		logic [2:0] step;
		logic rnw;
		logic [6:0] reg_a;
		logic [7:0] wdata;
		logic [7:0] sh;
		logic [7:0] rx;
		logic [7:0] rdata;
		logic nack;
		logic scl_low;
		logic sda_low;
		logic sclk;
		logic ss_n;
		logic mosi;
	} dsrp_regs_t;
endpackage

// >>> rtl/dsrp_sync_if.sv
`timescale 1ns/100ps
interface dsrp_sync_if #(parameter int W = 3);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport sampler(input raw, output synced);
	modport user(output raw, input synced);
endinterface

// >>> rtl/dsrp_sync.sv
`timescale 1ns/100ps
module dsrp_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Pins in, synchronised out
	dsrp_sync_if.sampler pins
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dsrp_sync_t;

	dsrp_sync_t r_r;
	dsrp_sync_t r_nxt;

	generate
		if (W < 1) begin : g_bad_w
			$error("dsrp_sync width must be at least one");
		end
	endgenerate

	// ==========================================
	// Two flip-flop chain
	always_comb begin
		r_nxt = r_r;
		r_nxt.s1 = pins.raw;
		r_nxt.s2 = r_r.s1;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r_r <= '1;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign pins.synced = r_r.s2;
endmodule

// >>> rtl/dsrp_host.sv
// Function
// - Drive transactions on only one of the two ports at a time.
// - Two-wire lines are only pulled low or released, never driven high.
// - Data changes while clock low; sampled while clock high; eight-bit bytes.
// - Data falling with clock high is start; rising is stop, bus idle.
// - After start, master sends seven-bit address plus direction bit.
// - Reading master acknowledges by pulling low; releasing means not-acknowledge.
// - Start while bus active is repeated start, a new address phase.
// - Four-wire clock idles low; host generates clock and starts transfers.
// - Clock phase one; both sides start driving on first clock edge.
// - Four-wire write clears direction bit and sends data right after command.
`timescale 1ns/100ps
`include "dsrp_map.svh"
module dsrp_host #(
	parameter int QTR_CYC = `DSRP_QTR_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Command port
	input wire logic i_req,
	input wire logic i_spi,
	input wire logic i_rnw,
	input wire logic [6:0] i_reg,
	input wire logic [7:0] i_wdata,
	output logic o_ready,
	output logic o_done,
	output logic [7:0] o_rdata,
	output logic o_nack,
	// Two-wire pins
	input wire logic i_scl,
	output logic o_scl_o,
	output logic o_scl_oe,
	input wire logic i_sda,
	output logic o_sda_o,
	output logic o_sda_oe,
	// Four-wire pins
	output logic o_sclk,
	output logic o_ss_n,
	output logic o_mosi,
	input wire logic i_miso
);
	localparam logic [`DSRP_CNT_W-1:0] RELOAD = `DSRP_CNT_W'(QTR_CYC - 1);
	localparam dsrp_pkg::dsrp_regs_t RST_V = '{
		st: dsrp_pkg::ST_IDLE, ss_n: 1'h1, default: '0};

	dsrp_pkg::dsrp_regs_t r_r;
	dsrp_pkg::dsrp_regs_t r_nxt;
	logic scl_s;
	logic sda_s;
	logic miso_s;
	logic stall;
	logic tick;
	logic fin;

	generate
		if (QTR_CYC < `DSRP_QTR_MIN || QTR_CYC >= (1 << `DSRP_CNT_W))
		begin : g_bad_qtr
			$error("dsrp_host QTR_CYC out of range");
		end
	endgenerate

	// ==========================================
	// Pin input synchronisers
	dsrp_sync_if #(.W(`DSRP_SYNC_W)) sync_if ();
	assign sync_if.raw = {i_scl, i_sda, i_miso};
	assign {scl_s, sda_s, miso_s} = sync_if.synced;

	dsrp_sync #(.W(`DSRP_SYNC_W)) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.pins(sync_if.sampler)
	);

	// ==========================================
	// Byte sent at each two-wire step
	function automatic logic [7:0] i2c_byte(input logic [2:0] s,
		input dsrp_pkg::dsrp_regs_t v);
		case (s)
			`DSRP_STEP_AW: return {`DSRP_DEV_ADDR, 1'h0};
			`DSRP_STEP_REG: return {1'h0, v.reg_a};
			`DSRP_STEP_DAT: return v.wdata;
			`DSRP_STEP_AR: return {`DSRP_DEV_ADDR, 1'h1};
			default: return `DSRP_RX_IDLE;
		endcase
	endfunction

	// ==========================================
	// Quarter-period timing, slave may stretch the clock in data and acknowledge bits, not in start or stop
	assign stall = (r_r.st == dsrp_pkg::ST_I2C_BIT) && r_r.q[1] && !scl_s;
	assign tick = (r_r.cnt == '0) && !stall;
	assign fin = tick && (r_r.q == `DSRP_Q_LAST);

	// ==========================================
	// Next state
	always_comb begin
		r_nxt = r_r;
		if (r_r.st == dsrp_pkg::ST_IDLE || r_r.st == dsrp_pkg::ST_DONE) begin
			r_nxt.cnt = RELOAD;
		end else if (tick) begin
			r_nxt.cnt = RELOAD;
			r_nxt.q = r_r.q + 2'h1;
		end else if (!stall) begin
			r_nxt.cnt = r_r.cnt - `DSRP_CNT_W'(1);
		end
		case (r_r.st)
			dsrp_pkg::ST_IDLE: begin
				if (i_req) begin
					r_nxt.rnw = i_rnw;
					r_nxt.reg_a = i_reg;
					r_nxt.wdata = i_wdata;
					r_nxt.nack = 1'h0;
					r_nxt.q = `DSRP_Q_FIRST;
					r_nxt.step = `DSRP_STEP_AW;
					r_nxt.st = i_spi ? dsrp_pkg::ST_SPI_START :
						dsrp_pkg::ST_I2C_START;
				end
			end
			dsrp_pkg::ST_I2C_START: begin
				if (fin) begin
					r_nxt.st = dsrp_pkg::ST_I2C_BIT;
					r_nxt.bitn = '0;
					r_nxt.sh = i2c_byte(r_r.step, r_r);
				end
			end
			dsrp_pkg::ST_I2C_BIT: begin
				if (fin) begin
					if (r_r.bitn != `DSRP_ACK_BIT) begin
						r_nxt.bitn = r_r.bitn + 5'h01;
						r_nxt.sh = {r_r.sh[6:0], 1'h1};
						if (r_r.step == `DSRP_STEP_RD) begin
							r_nxt.rx = {r_r.rx[6:0], sda_s};
						end
					end else if (r_r.step != `DSRP_STEP_RD && sda_s) begin
						r_nxt.nack = 1'h1;
						r_nxt.st = dsrp_pkg::ST_I2C_STOP;
					end else begin
						r_nxt.bitn = '0;
						case (r_r.step)
							`DSRP_STEP_AW: r_nxt.step = `DSRP_STEP_REG;
							`DSRP_STEP_REG: begin
								if (r_r.rnw) begin
									r_nxt.step = `DSRP_STEP_AR;
									r_nxt.st = dsrp_pkg::ST_I2C_START;
								end else begin
									r_nxt.step = `DSRP_STEP_DAT;
								end
							end
							`DSRP_STEP_AR: r_nxt.step = `DSRP_STEP_RD;
							default: r_nxt.st = dsrp_pkg::ST_I2C_STOP;
						endcase
						r_nxt.sh = i2c_byte(r_nxt.step, r_r);
					end
				end
			end
			dsrp_pkg::ST_I2C_STOP: begin
				if (fin) begin
					r_nxt.st = dsrp_pkg::ST_DONE;
					r_nxt.rdata = r_r.rx;
				end
			end
			dsrp_pkg::ST_SPI_START: begin
				if (fin) begin
					r_nxt.st = dsrp_pkg::ST_SPI_BIT;
					r_nxt.bitn = '0;
					r_nxt.sh = {r_r.reg_a, r_r.rnw};
				end
			end
			dsrp_pkg::ST_SPI_BIT: begin
				if (tick && r_r.q == `DSRP_Q_SPI_SMP &&
					r_r.bitn > `DSRP_SPI_CMD_LAST) begin
					r_nxt.rx = {r_r.rx[6:0], miso_s};
				end
				if (fin) begin
					if (r_r.bitn == `DSRP_SPI_LAST) begin
						r_nxt.st = dsrp_pkg::ST_SPI_END;
					end else begin
						r_nxt.bitn = r_r.bitn + 5'h01;
					end
					if (r_r.bitn == `DSRP_SPI_CMD_LAST) begin
						r_nxt.sh = r_r.rnw ? `DSRP_SPI_FILL : r_r.wdata;
					end else begin
						r_nxt.sh = {r_r.sh[6:0], 1'h0};
					end
				end
			end
			dsrp_pkg::ST_SPI_END: begin
				if (fin) begin
					r_nxt.st = dsrp_pkg::ST_DONE;
					r_nxt.rdata = r_r.rx;
				end
			end
			dsrp_pkg::ST_DONE: r_nxt.st = dsrp_pkg::ST_IDLE;
			default: r_nxt = RST_V;
		endcase

		// Pin levels; data bits move in the quarter after the clock fell, start and stop edges while the clock is high
		r_nxt.scl_low = 1'h0;
		r_nxt.sda_low = 1'h0;
		case (r_r.st)
			dsrp_pkg::ST_I2C_START: begin
				r_nxt.scl_low = !r_r.q[1];
				r_nxt.sda_low = (r_r.q == `DSRP_Q_FIRST) ? r_r.sda_low :
					(r_r.q == `DSRP_Q_LAST);
			end
			dsrp_pkg::ST_I2C_BIT: begin
				r_nxt.scl_low = !r_r.q[1];
				r_nxt.sda_low = (r_r.q == `DSRP_Q_FIRST) ? r_r.sda_low :
					(r_r.bitn != `DSRP_ACK_BIT) && !r_r.sh[7];
			end
			dsrp_pkg::ST_I2C_STOP: begin
				r_nxt.scl_low = !r_r.q[1];
				r_nxt.sda_low = (r_r.q == `DSRP_Q_FIRST) ? r_r.sda_low :
					(r_r.q != `DSRP_Q_LAST);
			end
			default: begin
				r_nxt.scl_low = 1'h0;
				r_nxt.sda_low = 1'h0;
			end
		endcase
		r_nxt.ss_n = !(r_r.st == dsrp_pkg::ST_SPI_START ||
			r_r.st == dsrp_pkg::ST_SPI_BIT ||
			r_r.st == dsrp_pkg::ST_SPI_END);
		r_nxt.sclk = (r_r.st == dsrp_pkg::ST_SPI_BIT) && !r_r.q[1];
		if (r_r.st == dsrp_pkg::ST_SPI_BIT && r_r.q == `DSRP_Q_FIRST) begin
			r_nxt.mosi = r_r.sh[7];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r_r <= RST_V;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ==========================================
	// Outputs
	assign o_ready = (r_r.st == dsrp_pkg::ST_IDLE);
	assign o_done = (r_r.st == dsrp_pkg::ST_DONE);
	assign o_rdata = r_r.rdata;
	assign o_nack = r_r.nack;
	assign o_scl_o = `DSRP_OD_LOW;
	assign o_sda_o = `DSRP_OD_LOW;
	assign o_scl_oe = r_r.scl_low;
	assign o_sda_oe = r_r.sda_low;
	assign o_sclk = r_r.sclk;
	assign o_ss_n = r_r.ss_n;
	assign o_mosi = r_r.mosi;

	// ==========================================
	// Checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	property p_one_port;
		!o_ss_n |-> !o_scl_oe && !o_sda_oe;
	endproperty
	a_one_port: assert property (p_one_port)
		else $error("two-wire pins pulled during four-wire frame");

	property p_released;
		(r_r.st == dsrp_pkg::ST_DONE) |=> !o_scl_oe && !o_sda_oe && o_ss_n;
	endproperty
	a_released: assert property (p_released)
		else $error("lines not released after transfer");

	property p_data_low_clk;
		(r_r.st == dsrp_pkg::ST_I2C_BIT && $changed(o_sda_oe))
			|-> o_scl_oe && $past(o_scl_oe);
	endproperty
	a_data_low_clk: assert property (p_data_low_clk)
		else $error("data moved while clock released");

	property p_start;
		$rose(o_sda_oe) && !o_scl_oe
			|-> $past(r_r.st) == dsrp_pkg::ST_I2C_START;
	endproperty
	a_start: assert property (p_start)
		else $error("data fell with clock high outside start");

	property p_stop;
		$fell(o_sda_oe) && !o_scl_oe
			|-> $past(r_r.st) == dsrp_pkg::ST_I2C_STOP;
	endproperty
	a_stop: assert property (p_stop)
		else $error("data rose with clock high outside stop");

	property p_addr_byte;
		$rose(r_r.st == dsrp_pkg::ST_I2C_BIT) |-> r_r.sh[7:1] == `DSRP_DEV_ADDR
			&& r_r.sh[0] == (r_r.step == `DSRP_STEP_AR);
	endproperty
	a_addr_byte: assert property (p_addr_byte)
		else $error("first byte after start is not the address");

	property p_read_nack;
		(r_r.st == dsrp_pkg::ST_I2C_BIT && r_r.step == `DSRP_STEP_RD &&
			r_r.bitn == `DSRP_ACK_BIT && r_r.q == `DSRP_Q_SCL_HI)
			|-> !o_sda_oe;
	endproperty
	a_read_nack: assert property (p_read_nack)
		else $error("last read byte not left unacknowledged");

	property p_rstart;
		$rose(r_r.st == dsrp_pkg::ST_I2C_START) && r_r.step == `DSRP_STEP_AR
			|-> $past(r_r.st) == dsrp_pkg::ST_I2C_BIT && r_r.rnw;
	endproperty
	a_rstart: assert property (p_rstart)
		else $error("read address phase not entered by repeated start");

	property p_clk_idle;
		o_ss_n |-> !o_sclk;
	endproperty
	a_clk_idle: assert property (p_clk_idle)
		else $error("serial clock high outside frame");

	property p_mosi_edge;
		$changed(o_mosi) |-> $rose(o_sclk);
	endproperty
	a_mosi_edge: assert property (p_mosi_edge)
		else $error("MOSI changed away from rising clock");

	property p_dir_bit;
		(r_r.st == dsrp_pkg::ST_SPI_BIT && r_r.bitn == `DSRP_SPI_CMD_LAST &&
			r_r.q == `DSRP_Q_SCL_HI) |-> o_mosi == r_r.rnw;
	endproperty
	a_dir_bit: assert property (p_dir_bit)
		else $error("command direction bit wrong");
endmodule

// >>> verif/dsrp_dev_model.sv
`timescale 1ns/100ps
module dsrp_dev_model #(
	parameter logic [6:0] DEV_ADDR = 7'h18
) (
	// Host pins
	input wire logic i_scl_oe,
	input wire logic i_sda_oe,
	input wire logic i_sclk,
	input wire logic i_ss_n,
	input wire logic i_mosi,
	// Wire levels
	output logic o_scl,
	output logic o_sda,
	output logic o_miso,
	// Behaviour controls
	input wire logic i_mute,
	input wire logic i_slow
);
	logic [7:0] mem [256][128];
	logic [7:0] page;
	logic [7:0] sr, tx, cmd, dat, stx;
	logic [6:0] ptr;
	logic act, rd, drv, drv_d, men, mval;
	int bitc, step, sbit;

	// ==========================================
	// Register file
	initial begin
		foreach (mem[p, r]) mem[p][r] = 8'h00;
		page = 8'h00;
		act = 1'h0;
		rd = 1'h0;
		drv = 1'h0;
		drv_d = 1'h0;
		men = 1'h0;
		mval = 1'h0;
	end

	function automatic logic [6:0] nxt(input logic [6:0] p);
		if (page == 8'hFC && (p == 7'h01 || p == 7'h02))
			return p ^ 7'h03;
		return (p == 7'h7F) ? p : p + 7'h01;
	endfunction

	function automatic logic [7:0] rdr(input logic [6:0] p);
		return (p == 7'h00) ? page : mem[page][p];
	endfunction

	// Shared by both ports
	task automatic wrr(input logic [6:0] p, input logic [7:0] d);
		if (p == 7'h00)
			page = d;
		else
			mem[page][p] = d;
	endtask

	// ==========================================
	// Two-wire slave, open drain only
	always @(drv) drv_d <= #(i_slow ? 60 : 1) drv;
	assign o_scl = !i_scl_oe;
	assign o_sda = !(i_sda_oe || drv_d);

	always @(negedge o_sda) if (o_scl) begin
		act = 1'h1;
		bitc = -1;
		step = 0;
		rd = 1'h0;
		drv = 1'h0;
	end

	always @(posedge o_sda) if (o_scl) begin
		act = 1'h0;
		drv = 1'h0;
	end

	always @(posedge o_scl) if (act) begin
		if (bitc < 8)
			sr = {sr[6:0], o_sda};
		else if (rd && o_sda)
			act = 1'h0;
	end

	always @(negedge o_scl) if (act) begin
		bitc = bitc + 1;
		if (bitc == 8 && rd) begin
			drv = 1'h0;
		end else if (bitc == 8) begin
			drv = !i_mute;
			if (step == 0) begin
				drv = drv && (sr[7:1] == DEV_ADDR || (sr == 8'h00
					&& mem[0][34][5]));
				rd = sr[0];
			end else if (step == 1) begin
				ptr = sr[6:0];
			end else begin
				wrr(ptr, sr);
				ptr = nxt(ptr);
			end
			step = (step == 0) ? 1 : 2;
			if (!drv)
				act = 1'h0;
		end else if (bitc == 9) begin
			bitc = 0;
			drv = 1'h0;
			if (rd) begin
				tx = rdr(ptr);
				ptr = nxt(ptr);
			end
		end
		if (rd && bitc < 8)
			drv = !tx[7 - bitc];
	end

	// ==========================================
	// Four-wire slave, mode 1
	always @(negedge i_ss_n) begin
		sbit = 0;
		men = 1'h1;
	end

	always @(posedge i_ss_n) begin
		sbit = 0;
		men = 1'h0;
	end

	always @(posedge i_sclk) if (!i_ss_n) begin
		if (sbit == 8 && cmd[0])
			stx = rdr(cmd[7:1]);
		mval = (sbit >= 8 && cmd[0]) ? stx[15 - sbit] : !mval;
	end

	always @(negedge i_sclk) if (!i_ss_n) begin
		if (sbit < 8)
			cmd = {cmd[6:0], i_mosi};
		else
			dat = {dat[6:0], i_mosi};
		sbit = sbit + 1;
		if (sbit == 16 && !cmd[0])
			wrr(cmd[7:1], dat);
	end

	// Released line wanders
	always #7 if (!men) mval = !mval;
	assign o_miso = mval;
endmodule

// >>> verif/test_dsrp_host.sv
`timescale 1ns/100ps
module test_dsrp_host;
	localparam int QTR = 4;
	logic i_clk, i_rst_n, i_req, i_spi, i_rnw;
	logic [6:0] i_reg;
	logic [7:0] i_wdata, o_rdata, d;
	logic o_ready, o_done, o_nack, mute, slow;
	logic scl, scl_o, scl_oe, sda, sda_o, sda_oe, sclk, ss_n, mosi, miso;
	logic [9:0] exp_q [$];
	logic [9:0] e_cur;
	logic [6:0] regs [3] = '{7'h01, 7'h4D, 7'h7F};
	int miscompares, check_count;

	dsrp_host #(.QTR_CYC(QTR)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_req(i_req), .i_spi(i_spi), .i_rnw(i_rnw), .i_reg(i_reg),
		.i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done),
		.o_rdata(o_rdata), .o_nack(o_nack), .i_scl(scl), .o_scl_o(scl_o),
		.o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(sda_o),
		.o_sda_oe(sda_oe), .o_sclk(sclk), .o_ss_n(ss_n), .o_mosi(mosi),
		.i_miso(miso));

	dsrp_dev_model dev (.i_scl_oe(scl_oe), .i_sda_oe(sda_oe),
		.i_sclk(sclk), .i_ss_n(ss_n), .i_mosi(mosi), .o_scl(scl),
		.o_sda(sda), .o_miso(miso), .i_mute(mute), .i_slow(slow));

	// ==========================================
	// Clock and reporting
	initial begin
		i_clk = 1'h0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic give_up;
		miscompares++;
		report_and_stop();
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// ==========================================
	// Driver: one request, note expected {chk, nack, rdata}
	task automatic xfer(input logic s, input logic r, input logic [6:0] a,
			input logic [7:0] wd, input logic [9:0] e);
		int n;
		n = 0;
		exp_q.push_back(e);
		@(negedge i_clk);
		while (o_ready !== 1'h1 && n < 5000) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 5000)
			give_up();
		@(posedge i_clk);
		i_req <= 1'h1;
		i_spi <= s;
		i_rnw <= r;
		i_reg <= a;
		i_wdata <= wd;
		@(posedge i_clk);
		i_req <= 1'h0;
	endtask

	// Wait until every queued result has been checked
	task automatic drain;
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 5000) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 5000)
			give_up();
	endtask

	// ==========================================
	// Monitor
	always @(negedge i_clk) if (i_rst_n) begin
		check({6'h00, scl_o, sda_o}, 8'h00);
		if (ss_n === 1'h1)
			check({7'h00, sclk}, 8'h00);
		if (o_done === 1'h1) begin
			if (exp_q.size() == 0)
				give_up();
			e_cur = exp_q.pop_front();
			check({7'h00, o_nack}, {7'h00, e_cur[8]});
			if (e_cur[9])
				check(o_rdata, e_cur[7:0]);
		end
	end

	initial begin
		repeat (100000) @(posedge i_clk);
		give_up();
	end

	// ==========================================
	// Main sequence
	initial begin
		i_rst_n = 1'h0;
		i_req = 1'h0;
		i_spi = 1'h0;
		i_rnw = 1'h0;
		i_reg = 7'h00;
		i_wdata = 8'h00;
		mute = 1'h0;
		slow = 1'h0;
		miscompares = 0;
		check_count = 0;
		void'($urandom(32'hC311));
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'h1;
		@(negedge i_clk);
		check({o_ready, o_done, o_nack, scl_oe, sda_oe, sclk, ss_n, mosi},
			8'h82);
		xfer(1'h1, 1'h1, 7'h00, 8'h00, 10'h200);
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 3; k++) begin
				d = 8'($urandom);
				xfer(p[0], 1'h0, regs[k], d, 10'h000);
				xfer(!p[0], 1'h1, regs[k], 8'($urandom), {2'h2, d});
				xfer(p[0], 1'h1, regs[k], 8'($urandom), {2'h2, d});
			end
		end
		drain();
		slow = 1'h1;
		d = 8'($urandom);
		xfer(1'h0, 1'h0, 7'h00, 8'h03, 10'h000);
		xfer(1'h1, 1'h0, 7'h05, d, 10'h000);
		xfer(1'h0, 1'h1, 7'h00, 8'h00, 10'h203);
		xfer(1'h0, 1'h1, 7'h05, 8'h00, {2'h2, d});
		xfer(1'h1, 1'h0, 7'h00, 8'h00, 10'h000);
		xfer(1'h0, 1'h1, 7'h05, 8'h00, 10'h200);
		drain();
		slow = 1'h0;
		mute = 1'h1;
		xfer(1'h0, 1'h0, 7'h09, 8'h55, 10'h100);
		xfer(1'h0, 1'h1, 7'h09, 8'h00, 10'h100);
		drain();
		mute = 1'h0;
		xfer(1'h0, 1'h1, 7'h09, 8'h00, 10'h200);
		drain();
		report_and_stop();
	end
endmodule
